// ===== inc/ulb_pkg.sv
// ulb_pkg: register map, field positions, reset values and frame sizes
// assumes a 32-bit classic Wishbone register bus, one word per register
package ulb_pkg;
    // register byte offsets
    localparam logic [4:0] OFF_MODE   = 5'h00; // op_mode_reg
    localparam logic [4:0] OFF_CTRL   = 5'h04; // serial_control_reg
    localparam logic [4:0] OFF_CKSEL  = 5'h08; // clock_select_reg
    localparam logic [4:0] OFF_DIV    = 5'h0C; // baud_divisor_reg
    localparam logic [4:0] OFF_ERR    = 5'h10; // rx_error_status, clear on read
    localparam logic [4:0] OFF_RXB    = 5'h14; // rx_buffer, read only
    localparam logic [4:0] OFF_TXB    = 5'h18; // tx_buffer, write only
    // op_mode_reg fields
    localparam int MODE_POWER = 7;
    localparam int MODE_TXE   = 6;
    localparam int MODE_RXE   = 5;
    localparam int MODE_MERGE = 0;
    // serial_control_reg fields
    localparam int CTRL_BRF   = 7;
    localparam int CTRL_BRE   = 6;
    localparam int CTRL_BTT   = 5;
    localparam int CTRL_BL_HI = 4;
    localparam int CTRL_BL_LO = 2;
    // rx_error_status fields
    localparam int ERR_OVE = 0;
    localparam int ERR_PE  = 1;
    localparam int ERR_FE  = 2;
    // reset values
    localparam logic [7:0] RXB_RST = 8'hFF;
    localparam logic [7:0] DIV_RST = 8'hFF;
    localparam logic [3:0] CKSEL_RST = 4'h0;
    // base clock selection
    localparam logic [3:0] CKSEL_MAXDIV = 4'hA; // codes 0..10: divide by 2^code
    localparam logic [3:0] CKSEL_TIMER  = 4'hB; // code 11: timer output
    localparam int PRES_W = 10;
    // frame shape
    localparam logic [4:0] DATA_BITS  = 5'd8;
    localparam logic [3:0] FRAME_BITS = 4'd10; // start, 8 data, stop
    localparam logic [4:0] BRK_TX_MIN = 5'd13;
    localparam logic [4:0] BRK_RX_MIN = 5'd11;
    localparam logic [4:0] BIT_SAT    = 5'd31;
    // state types
    typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_BREAK} ulb_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ulb_rx_st_t;
endpackage : ulb_pkg

// ===== verilog/ulb_uart.sv
// ulb_uart: serial unit with receive noise filter, break field send and
// detect, and a baud generator with separate transmit and receive counters
// assumes synchronous pins, a classic Wishbone master, one clock ref_clk
//
// Overview of operation
// - merge set: errors go on receive-done event
// - merge clear: errors on separate error event
// - input accepted after two equal samples
// - reception lags line by three base clocks
// - power on drives output pin high
// - trigger write with power, enable starts break
// - break holds pin low 13 to 20 bits
// - break end: done event, trigger cleared
// - after break idle until data or trigger
// - break receive enable arms break detection
// - low of 11+ bits: done, clear flags
// - no error flags during break reception
// - break never loads receive buffer
// - short break: no event, flags kept
// - base clock only while powered
// - codes 0-10 divide, 11 timer, others off
// - separate 8-bit transmit and receive counters
// - transmit counter zero unless powered, enabled
// - transmit counter cleared on frame start
// - receive counter runs only within frames
// - bit rate is base over twice divisor
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module ulb_uart
    import ulb_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // serial line and timer source
    input  wire logic        serial_in_pin,
    input  wire logic        timer_event_counter_out,
    output logic             serial_out_pin,
    // event pulses
    output logic             tx_done_irq,
    output logic             rx_done_irq,
    output logic             rx_error_irq
);

    // mask of the low code bits of the prescaler
    function automatic logic [PRES_W-1:0] pres_mask(input logic [3:0] code);
        pres_mask = PRES_W'((1 << code) - 1);
    endfunction : pres_mask

    // registers
    logic             power_q, tx_en_q, rx_en_q, merge_q;
    logic             brk_rx_en_q, brk_rx_flag_q, brk_tx_trig_q;
    logic [2:0]       brk_len_q;
    logic [3:0]       base_clock_sel_q;
    logic [7:0]       baud_divisor_value_q;
    logic [2:0]       err_q;
    logic [7:0]       rx_buffer_q, tx_buffer_q, rx_shift_reg_q;
    logic             rxb_full_q, txb_full_q;
    logic [PRES_W-1:0] pres_q;
    logic             tmr_prev_q;
    logic             samp1_q, samp2_q, filt_q, filt_prev_q;
    logic [7:0]       tx_cnt_q, rx_cnt_q;
    logic             tx_half_q, rx_half_q;
    logic [9:0]       tx_shift_q;
    logic [4:0]       tx_bits_q, rx_bits_q;
    ulb_tx_st_t       tx_st_q;
    ulb_rx_st_t       rx_st_q;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr      = bus_req & wb_we_i & wb_sel_i[0];
    wire rd      = bus_req & ~wb_we_i;
    wire wr_mode = wr && wb_adr_i == OFF_MODE;
    wire wr_ctrl = wr && wb_adr_i == OFF_CTRL;
    wire wr_ck   = wr && wb_adr_i == OFF_CKSEL;
    wire wr_div  = wr && wb_adr_i == OFF_DIV;
    wire wr_txb  = wr && wb_adr_i == OFF_TXB;
    wire rd_err  = rd && wb_adr_i == OFF_ERR;
    wire rd_rxb  = rd && wb_adr_i == OFF_RXB;
    wire tx_on   = power_q & tx_en_q;
    wire rx_on   = power_q & rx_en_q;
    wire brk_rx  = rx_on & brk_rx_en_q;

    // divide by two to the code or timer edge
    wire timer_rise = timer_event_counter_out & ~tmr_prev_q;
    wire base_tick  = power_q & (
        (base_clock_sel_q <= CKSEL_MAXDIV)
            ? ((pres_q & pres_mask(base_clock_sel_q)) == pres_mask(base_clock_sel_q))
            : (base_clock_sel_q == CKSEL_TIMER) & timer_rise);

    // half bit after k base clocks, bit after two halves
    wire tx_half_tick = base_tick && tx_cnt_q == baud_divisor_value_q - 8'd1;
    wire rx_half_tick = base_tick && rx_cnt_q == baud_divisor_value_q - 8'd1;
    wire tx_bit_tick  = tx_half_tick & tx_half_q;
    wire rx_bit_tick  = rx_half_tick & rx_half_q;

    // transmitter sequencing terms
    wire tx_start_data = tx_on && tx_st_q == TX_IDLE && txb_full_q && !brk_tx_trig_q;
    wire tx_start_brk  = tx_on && tx_st_q == TX_IDLE && brk_tx_trig_q;
    wire tx_frame_end  = tx_st_q == TX_FRAME && tx_bit_tick
                         && tx_bits_q == 5'(FRAME_BITS - 4'd1);
    // low time of 13 plus the length code
    wire tx_brk_end    = tx_st_q == TX_BREAK && tx_bit_tick
                         && tx_bits_q == BRK_TX_MIN + 5'(brk_len_q) - 5'd1;

    // receiver sequencing terms
    wire rx_fall    = rx_st_q == RX_IDLE && filt_prev_q & ~filt_q;
    wire rx_go      = rx_st_q == RX_START && rx_half_tick && !filt_q;
    wire rx_abort   = rx_st_q == RX_START && rx_half_tick && filt_q;
    wire rx_samp    = rx_st_q == RX_DATA && rx_bit_tick;
    wire rx_stop    = rx_samp && !brk_rx && rx_bits_q == DATA_BITS;
    wire brk_end    = rx_samp && brk_rx && filt_q;
    // break of eleven bits or more is taken
    wire brk_ok     = brk_end && rx_bits_q >= BRK_RX_MIN;
    wire fe_set     = rx_stop & ~filt_q;
    wire ove_set    = rx_stop & rxb_full_q;
    wire rx_err     = fe_set | ove_set;

    // prescaler and timer edge history
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pres_q     <= '0;
            tmr_prev_q <= 1'b0;
        end else begin
            pres_q     <= power_q ? pres_q + PRES_W'(1) : '0;
            tmr_prev_q <= timer_event_counter_out;
        end
    end

    // mode, clock and divisor registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {power_q, tx_en_q, rx_en_q, merge_q} <= 4'h0;
            base_clock_sel_q     <= CKSEL_RST;
            baud_divisor_value_q <= DIV_RST;
            brk_len_q            <= 3'h0;
        end else begin
            if (wr_mode) begin
                power_q <= wb_dat_i[MODE_POWER];
                tx_en_q <= wb_dat_i[MODE_TXE];
                rx_en_q <= wb_dat_i[MODE_RXE];
                merge_q <= wb_dat_i[MODE_MERGE];
            end
            if (wr_ck)
                base_clock_sel_q <= wb_dat_i[3:0];
            if (wr_div)
                baud_divisor_value_q <= wb_dat_i[7:0];
            if (wr_ctrl)
                brk_len_q <= wb_dat_i[CTRL_BL_HI:CTRL_BL_LO];
        end
    end

    // break control bits: a software set wins over the hardware clear at break end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            brk_tx_trig_q <= 1'b0;
            brk_rx_en_q   <= 1'b0;
            brk_rx_flag_q <= 1'b0;
        end else begin
            // trigger set by software, cleared at break end
            if (!tx_on || (tx_brk_end && !(wr_ctrl && wb_dat_i[CTRL_BTT])))
                brk_tx_trig_q <= 1'b0;
            else if (wr_ctrl && wb_dat_i[CTRL_BTT])
                brk_tx_trig_q <= 1'b1;
            if (wr_ctrl && wb_dat_i[CTRL_BRE])
                brk_rx_en_q <= 1'b1;
            else if (brk_ok || wr_ctrl)
                brk_rx_en_q <= 1'b0;
            if (brk_ok || !brk_rx)
                brk_rx_flag_q <= 1'b0;
            else if (rx_go)
                brk_rx_flag_q <= 1'b1;
        end
    end

    // transmit buffer holding register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_buffer_q <= 8'h00;
            txb_full_q  <= 1'b0;
        end else begin
            if (wr_txb && tx_on)
                tx_buffer_q <= wb_dat_i[7:0];
            if (wr_txb && tx_on)
                txb_full_q <= 1'b1;
            else if (tx_start_data || !tx_on)
                txb_full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cnt_q  <= 8'h00;
            tx_half_q <= 1'b0;
        end else if (!tx_on || tx_start_data || tx_start_brk) begin
            tx_cnt_q  <= 8'h00;
            tx_half_q <= 1'b0;
        end else if (tx_half_tick) begin
            tx_cnt_q  <= 8'h00;
            tx_half_q <= ~tx_half_q;
        end else if (base_tick) begin
            tx_cnt_q  <= tx_cnt_q + 8'd1;
        end
    end

    // transmitter state and shifter
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q    <= TX_IDLE;
            tx_shift_q <= '1;
            tx_bits_q  <= 5'd0;
        end else if (!tx_on) begin
            tx_st_q    <= TX_IDLE;
            tx_shift_q <= '1;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    tx_bits_q <= 5'd0;
                    if (tx_start_brk) begin
                        tx_st_q    <= TX_BREAK;
                        tx_shift_q <= '0;
                    end else if (tx_start_data) begin
                        tx_st_q    <= TX_FRAME;
                        tx_shift_q <= {1'b1, tx_buffer_q, 1'b0};
                    end
                end
                TX_FRAME: if (tx_bit_tick) begin
                    tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                    tx_bits_q  <= tx_bits_q + 5'd1;
                    if (tx_frame_end)
                        tx_st_q <= TX_IDLE;
                end
                TX_BREAK: if (tx_bit_tick) begin
                    tx_bits_q <= tx_bits_q + 5'd1;
                    // back to idle, waits for data or trigger
                    if (tx_brk_end) begin
                        tx_st_q    <= TX_IDLE;
                        tx_shift_q <= '1;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // two samples and a match detector
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            samp1_q     <= 1'b1;
            samp2_q     <= 1'b1;
            filt_q      <= 1'b1;
            filt_prev_q <= 1'b1;
        end else if (base_tick) begin
            samp1_q <= serial_in_pin;
            samp2_q <= samp1_q;
            // filtered level lags the pin by three base clocks
            if (samp1_q == samp2_q)
                filt_q <= samp2_q;
            filt_prev_q <= filt_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt_q  <= 8'h00;
            rx_half_q <= 1'b0;
        end else if (!rx_on || rx_st_q == RX_IDLE || rx_go) begin
            rx_cnt_q  <= 8'h00;
            rx_half_q <= 1'b0;
        end else if (rx_half_tick) begin
            rx_cnt_q  <= 8'h00;
            rx_half_q <= ~rx_half_q;
        end else if (base_tick) begin
            rx_cnt_q  <= rx_cnt_q + 8'd1;
        end
    end

    // receiver state, shifter and bit count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q        <= RX_IDLE;
            rx_shift_reg_q <= 8'h00;
            rx_bits_q      <= 5'd0;
        end else if (!rx_on) begin
            rx_st_q <= RX_IDLE;
        end else begin
            case (rx_st_q)
                // start detection alike in both modes
                RX_IDLE: if (rx_fall)
                    rx_st_q <= RX_START;
                RX_START: begin
                    rx_bits_q <= brk_rx ? 5'd1 : 5'd0;
                    if (rx_go)
                        rx_st_q <= RX_DATA;
                    else if (rx_abort)
                        rx_st_q <= RX_IDLE;
                end
                RX_DATA: if (rx_samp) begin
                    rx_shift_reg_q <= {filt_q, rx_shift_reg_q[7:1]};
                    if (rx_bits_q != BIT_SAT)
                        rx_bits_q <= rx_bits_q + 5'd1;
                    // short break returns to break detection
                    if (rx_stop || brk_end)
                        rx_st_q <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // receive buffer and error status, set wins over read clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_buffer_q <= RXB_RST;
            rxb_full_q  <= 1'b0;
            err_q       <= 3'h0;
        end else begin
            // only normal frames without overrun load the buffer
            if (rx_stop && !rxb_full_q)
                rx_buffer_q <= rx_shift_reg_q;
            if (rx_stop && !rxb_full_q)
                rxb_full_q <= 1'b1;
            else if (rd_rxb)
                rxb_full_q <= 1'b0;
            // flags only set by normal frames
            err_q[ERR_OVE] <= ove_set | (err_q[ERR_OVE] & ~rd_err);
            err_q[ERR_FE]  <= fe_set  | (err_q[ERR_FE]  & ~rd_err);
            err_q[ERR_PE]  <= err_q[ERR_PE] & ~rd_err;
        end
    end

    // event pulses and serial output
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_out_pin <= 1'b1;
            tx_done_irq    <= 1'b0;
            rx_done_irq    <= 1'b0;
            rx_error_irq   <= 1'b0;
        end else begin
            serial_out_pin <= tx_on ? tx_shift_q[0] : 1'b1;
            // done after frames and break fields
            tx_done_irq    <= tx_on & (tx_frame_end | tx_brk_end);
            // merged errors ride on receive done
            rx_done_irq    <= rx_on & (brk_ok | (rx_stop & (~rx_err | merge_q)));
            // separate error event when not merged
            rx_error_irq   <= rx_on & rx_err & ~merge_q;
        end
    end

    // read data mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            OFF_MODE: begin
                rd_mux[MODE_POWER] = power_q;
                rd_mux[MODE_TXE]   = tx_en_q;
                rd_mux[MODE_RXE]   = rx_en_q;
                rd_mux[MODE_MERGE] = merge_q;
            end
            OFF_CTRL: begin
                rd_mux[CTRL_BRF] = brk_rx_flag_q;
                rd_mux[CTRL_BRE] = brk_rx_en_q;
                rd_mux[CTRL_BTT] = brk_tx_trig_q;
                rd_mux[CTRL_BL_HI:CTRL_BL_LO] = brk_len_q;
            end
            OFF_CKSEL: rd_mux[3:0] = base_clock_sel_q;
            OFF_DIV:   rd_mux[7:0] = baud_divisor_value_q;
            OFF_ERR:   rd_mux[2:0] = err_q;
            OFF_RXB:   rd_mux[7:0] = rx_buffer_q;
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // one-wait-state acknowledge, read data registered
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule : ulb_uart

// ===== bench/ulb_uart_props.sv
// ulb_uart_props: port-level checks on the serial unit
// assumes it is bound into ulb_uart, one clock ref_clk, reset rst_b
`timescale 1ns/1ps
module ulb_uart_props
    import ulb_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // serial line and events
    input wire logic        serial_in_pin,
    input wire logic        timer_event_counter_out,
    input wire logic        serial_out_pin,
    input wire logic        tx_done_irq,
    input wire logic        rx_done_irq,
    input wire logic        rx_error_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic pwr_q;
    logic txe_q;
    logic mrg_q;
    // mode write taken on the bus
    wire mode_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                   && (wb_adr_i == OFF_MODE);
    // any receive event
    wire rx_any = rx_done_irq || rx_error_irq;
    // shadow copy of the power, transmit enable and merge mode bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {pwr_q, txe_q, mrg_q} <= 3'b000;
        end else if (mode_wr) begin
            {pwr_q, txe_q, mrg_q} <= {wb_dat_i[MODE_POWER], wb_dat_i[MODE_TXE],
                                      wb_dat_i[MODE_MERGE]};
        end
    end
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_take |=> s_ack_once)
        else $error("ack not a single pulse after request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    AST_MERGE_NO_ERR: assert property (mrg_q && $past(mrg_q) |-> !rx_error_irq)
        else $error("error event while merged");
    AST_IDLE_HIGH: assert property (!pwr_q && !$past(pwr_q) |-> serial_out_pin)
        else $error("output low while unpowered");
    AST_RX_UNPOWERED: assert property (!pwr_q && !$past(pwr_q) |-> !rx_any)
        else $error("receive event while unpowered");
    AST_TX_DISABLED: assert property (!txe_q && !$past(txe_q) |-> !tx_done_irq)
        else $error("transmit event while disabled");
    AST_DONE_HIGH: assert property (tx_done_irq |=> serial_out_pin)
        else $error("line low after transmit done");
    AST_RX_PULSE: assert property (rx_any |=> !rx_any)
        else $error("receive event longer than one cycle");
    AST_RX_EXCL: assert property (!(rx_done_irq && rx_error_irq))
        else $error("done and error together");
endmodule : ulb_uart_props

bind ulb_uart ulb_uart_props u_props (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_in_pin,
    .timer_event_counter_out, .serial_out_pin, .tx_done_irq, .rx_done_irq, .rx_error_irq);

// ===== bench/ulb_lin_node.sv
// ulb_lin_node: remote node driving the unit's receive line
// assumes calls start just after a rising edge, line idles high
`timescale 1ns/1ps
module ulb_lin_node (
    // clock
    input wire logic ref_clk,
    // line toward the unit
    output logic     line
);
    initial line = 1'b1;
    // hold one level for bt cycles
    task automatic put(input logic v, input int bt);
        line <= v;
        repeat (bt) @(posedge ref_clk);
    endtask : put
    // start, data lsb first, chosen stop level, then idle
    task automatic frame(input logic [7:0] d, input logic stp, input int bt);
        put(1'b0, bt);
        for (int i = 0; i < 8; i++) begin
            put(d[i], bt);
        end
        put(stp, bt);
        put(1'b1, bt);
    endtask : frame
    task automatic brk(input int nb, input int bt);
        put(1'b0, nb * bt);
        put(1'b1, 2 * bt);
    endtask : brk
endmodule : ulb_lin_node

// ===== bench/tb_ulb_uart.sv
// tb_ulb_uart: register tasks and serial scenarios for the unit
// assumes ulb_uart with bound checker and a node on the receive line
`timescale 1ns/1ps
module tb_ulb_uart
    import ulb_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rd;
    wire  [31:0] rdat;
    wire         ack, tx_pin, rx_pin, tx_ev, rx_ev, er_ev;
    int          err_total = 0, comparisons = 0, cycles = 0;
    int          n_tx = 0, n_rx = 0, n_er = 0, t0, t1, n;
    logic        tmr = 1'b0;

    ulb_uart DUT (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .serial_in_pin(rx_pin), .timer_event_counter_out(tmr),
        .serial_out_pin(tx_pin), .tx_done_irq(tx_ev), .rx_done_irq(rx_ev),
        .rx_error_irq(er_ev));
    ulb_lin_node node (.ref_clk(ref_clk), .line(rx_pin));

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    // timer output rises every second cycle
    always @(posedge ref_clk) tmr <= ~tmr;
    // count event pulses, cut a hang short
    always @(posedge ref_clk) begin
        n_tx += int'(tx_ev === 1'b1);
        n_rx += int'(rx_ev === 1'b1);
        n_er += int'(er_ev === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one classic cycle, read data left in rd
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        rd = rdat;
        chk("ack", 32'h0000_0001, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    // wait until some event pulse is counted
    task automatic wait_ev(input int lim);
        int s;
        s = n_tx + n_rx + n_er;
        for (int i = 0; i < lim && n_tx + n_rx + n_er == s; i++) @(posedge ref_clk);
        @(posedge ref_clk);
    endtask : wait_ev
    task automatic wait_low();
        for (int i = 0; i < 20 && tx_pin !== 1'b0; i++) @(posedge ref_clk);
    endtask : wait_low
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        wb(1'b0, OFF_DIV, 8'h00);
        chk("divisor reset", {24'h0, DIV_RST}, rd);
        wb(1'b0, OFF_RXB, 8'h00);
        chk("buffer reset", {24'h0, RXB_RST}, rd);
        wb(1'b0, 5'h1C, 8'h00);
        chk("unmapped", 32'h0000_0000, rd);
        wb(1'b1, OFF_CKSEL, 8'h00);
        wb(1'b1, OFF_DIV, 8'h04);
        wb(1'b1, OFF_MODE, 8'hE0);
        chk("idle pin", 32'h0000_0001, {31'h0, tx_pin});
        // byte 0x55 at eight cycles a bit
        t0 = n_tx;
        wb(1'b1, OFF_TXB, 8'h55);
        wait_low();
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            n = (i == 0) ? 0 : (i == 9) ? 1 : int'((8'h55 >> (i - 1)) & 8'h01);
            chk("tx bit", n, {31'h0, tx_pin});
            repeat (8) @(posedge ref_clk);
        end
        wait_ev(30);
        chk("tx done", t0 + 1, n_tx);
        // every break length code
        for (int c = 0; c < 8; c++) begin
            t0 = n_tx;
            wb(1'b1, OFF_CTRL, 8'(8'h20 | (c << 2)));
            wait_low();
            n = 0;
            while (tx_pin === 1'b0 && n < 400) begin
                @(posedge ref_clk);
                n++;
            end
            chk("break cycles", (13 + c) * 8, n);
            wait_ev(20);
            chk("break done", t0 + 1, n_tx);
            wb(1'b0, OFF_CTRL, 8'h00);
            chk("trigger cleared", c << 2, rd);
            repeat (40) @(posedge ref_clk);
            chk("stays idle", t0 + 1, n_tx);
        end
        // short then long break while armed
        wb(1'b1, OFF_CTRL, 8'h40);
        t0 = n_rx;
        node.brk(9, 8);
        repeat (40) @(posedge ref_clk);
        chk("short break", t0, n_rx);
        wb(1'b0, OFF_CTRL, 8'h00);
        chk("still armed", 32'h0000_00C0, rd);
        node.brk(12, 8);
        wait_ev(60);
        chk("long break", t0 + 1, n_rx);
        wb(1'b0, OFF_CTRL, 8'h00);
        chk("disarmed", 32'h0000_0000, rd);
        wb(1'b0, OFF_ERR, 8'h00);
        chk("break errors", 32'h0000_0000, rd);
        wb(1'b0, OFF_RXB, 8'h00);
        chk("break buffer", 32'h0000_00FF, rd);
        // a line toggling every cycle never settles, so no frame starts
        t1 = n_er;
        for (int i = 0; i < 48; i++) begin
            node.put(1'b0, 1);
            node.put(1'b1, 1);
        end
        node.put(1'b1, 60);
        chk("glitch", t0 + 1 + t1, n_rx + n_er);
        node.frame(8'hA5, 1'b1, 8);
        wait_ev(40);
        chk("rx done", t0 + 2, n_rx);
        wb(1'b0, OFF_RXB, 8'h00);
        chk("rx data", 32'h0000_00A5, rd);
        // framing error, separate then merged
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, OFF_MODE, 8'(8'hE0 | m));
            t0 = n_rx;
            t1 = n_er;
            node.frame(8'h3C, 1'b0, 8);
            wait_ev(40);
            chk("done events", t0 + m, n_rx);
            chk("error events", t1 + 1 - m, n_er);
            wb(1'b0, OFF_ERR, 8'h00);
            chk("framing flag", 32'h0000_0004, rd);
            wb(1'b0, OFF_RXB, 8'h00);
        end
        // timer edges as base clock: sixteen cycles a bit
        wb(1'b1, OFF_CKSEL, 8'h0B);
        wb(1'b1, OFF_TXB, 8'h01);
        wait_low();
        while (tx_pin === 1'b0) @(posedge ref_clk);
        while (tx_pin === 1'b1) @(posedge ref_clk);
        n = 0;
        while (tx_pin === 1'b0 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        chk("timer bits", 7 * 16, n);
        // unpowered unit ignores the line
        wb(1'b1, OFF_MODE, 8'h00);
        t0 = n_rx + n_er;
        node.frame(8'h11, 1'b1, 8);
        repeat (20) @(posedge ref_clk);
        chk("unpowered rx", t0, n_rx + n_er);
        chk("unpowered pin", 32'h0000_0001, {31'h0, tx_pin});
        summarize();
    end
endmodule : tb_ulb_uart
